// ===== core/rrbu_pkg.sv
/*
 * package for the upper run-time register bank: offsets, field positions,
 * reset values and widths shared by the bank and its leaf modules.
 * assumes an 8-bit host data bus with an 8-bit offset inside a 256-location block.
 */
package rrbu_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;  // host data bus width
	localparam int ADDR_W = 8;  // offset inside the 256-location block

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_DRIVE_A = 8'h08;
	localparam logic [7:0] OFS_DRIVE_B = 8'h09;
	localparam logic [7:0] OFS_INCELL_A = 8'h0A;
	localparam logic [7:0] OFS_INCELL_B = 8'h0B;
	localparam logic [7:0] OFS_OESTATE_A = 8'h0C;
	localparam logic [7:0] OFS_OESTATE_B = 8'h0D;
	localparam logic [7:0] OFS_DRIVE_C = 8'h16;
	localparam logic [7:0] OFS_DRIVE_D = 8'h17;
	localparam logic [7:0] OFS_INCELL_C = 8'h18;
	localparam logic [7:0] OFS_OESTATE_C = 8'h1A;
	localparam logic [7:0] OFS_OESTATE_D = 8'h1B;
	localparam logic [7:0] OFS_CELL_LOW = 8'h20;
	localparam logic [7:0] OFS_CELL_HIGH = 8'h21;
	localparam logic [7:0] OFS_MASK_LOW = 8'h22;
	localparam logic [7:0] OFS_MASK_HIGH = 8'h23;
	localparam logic [7:0] OFS_POWER_0 = 8'hB0;
	localparam logic [7:0] OFS_POWER_2 = 8'hB4;
	localparam logic [7:0] OFS_MAIN_PROT = 8'hC0;
	localparam logic [7:0] OFS_SEC_PROT = 8'hC2;
	localparam logic [7:0] OFS_POWER_3 = 8'hC7;
	localparam logic [7:0] OFS_PAGE = 8'hE0;
	localparam logic [7:0] OFS_MEM_MAP = 8'hE2;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int POWER3_STICKY_BIT = 1;  // set by software, cleared only by reset
	localparam int MAP_PORT_A_PERIPHERAL_IO_ENABLE_BIT = 7;     // port A peripheral i/o enable
	localparam int SECURE_BIT = 0;         // security flag position in C2h

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_DRIVE = 8'h00;    // 0 = cmos push-pull / normal slew
	localparam logic [7:0] RST_CELL = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_POWER = 8'h00;
	localparam logic [7:0] RST_PAGE = 8'h00;
	localparam logic [7:0] MAP_NV_FIELDS = 8'h1E;  // bits 4..1 taken from nv setting
	localparam logic [7:0] RST_ZERO = 8'h00;       // unmapped read value

endpackage

// ===== core/rrbu_cell_bank.sv
/*
 * one bank of eight output macrocell flip-flops with its mask register.
 * assumes the bank's logic inputs come from the same clock domain.
 */
module rrbu_cell_bank (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// logic-side load of the flip-flops
	input wire logic [7:0] logic_d_i,
	// host write strobes and data
	input wire logic cell_we_i,
	input wire logic mask_we_i,
	input wire logic [7:0] wdata_i,
	// state
	output logic [7:0] cell_o,
	output logic [7:0] mask_o
);

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	logic [7:0] cell_reg, cell_next;  // macrocell flip-flops
	logic [7:0] mask_reg, mask_next;  // per-cell host mask

	// masked cells keep following the logic; unmasked cells take the host byte
	always_comb begin
		cell_next = logic_d_i;
		mask_next = mask_reg;
		if (cell_we_i) begin
			cell_next = (wdata_i & ~mask_reg) | (logic_d_i & mask_reg);
		end
		if (mask_we_i) begin
			mask_next = wdata_i;
		end
	end

	// registers only
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cell_reg <= rrbu_pkg::RST_CELL;
			mask_reg <= rrbu_pkg::RST_MASK;
		end else begin
			cell_reg <= cell_next;
			mask_reg <= mask_next;
		end
	end

	assign cell_o = cell_reg;
	assign mask_o = mask_reg;

	// masked bit of a host write follows the logic, not the written byte
	mask_blocks_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		cell_we_i |=> ((cell_reg & $past(mask_reg)) == ($past(logic_d_i) & $past(mask_reg))))
		else $error("masked macrocell was written by host");

endmodule

// ===== core/rrbu_sync2.sv
/*
 * two-flip-flop synchroniser for a vector of pin levels.
 * assumes the inputs are asynchronous levels, not pulses.
 */
module rrbu_sync2 #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// asynchronous in, synchronous out
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	// a zero-width vector has nothing to carry
	if (WIDTH < 1) begin : g_width_chk
		$error("synchroniser width must be at least one");
	end

	// ----------------------------------------------------------------
	// two stages; first stage read only by the second
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] meta_reg, meta_next;
	logic [WIDTH-1:0] sync_reg, sync_next;

	// next values
	always_comb begin
		meta_next = async_i;
		sync_next = meta_reg;
	end

	// registers only
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_o = sync_reg;

endmodule

// ===== core/rrbu_bank.sv
/*
 * upper run-time register bank: drive select, input macrocell and
 * output-enable status, output macrocell banks and masks, flash protection
 * status, power registers, page and memory-space map, on an 8-bit host bus.
 * assumes a synchronous host bus on clk_i with one-cycle read/write strobes;
 * macrocell logic and nv settings arrive as inputs; pin levels are async.
 */
// Notes on behaviour
// - drive select per port, writable and readable
// - drive select resets to push-pull
// - input macrocell registers read-only, live state
// - output-enable status read-only, 1 means driving
// - low cell bank reads and loads cells
// - high cell bank reads and loads cells
// - mask bit one blocks host access
// - main flash protection read-only nv value
// - security and secondary protection read-only
// - power registers 0 and 2 read-write
// - power 3 bit 1 cleared only by reset
// - memory map reloads nv bits 4..1 on reset, other bits zero
// - port A peripheral enable resets to zero
module rrbu_bank (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// host register bus
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// input macrocell pin levels (asynchronous)
	input wire logic [7:0] input_macrocell_a_i,
	input wire logic [7:0] input_macrocell_b_i,
	input wire logic [7:0] input_macrocell_c_i,
	// driver enable states per port (asynchronous)
	input wire logic [7:0] drv_en_a_i,
	input wire logic [7:0] drv_en_b_i,
	input wire logic [7:0] drv_en_c_i,
	input wire logic [7:0] drv_en_d_i,
	// output macrocell logic next values
	input wire logic [7:0] output_macrocell_low_d_i,
	input wire logic [7:0] output_macrocell_high_d_i,
	// non-volatile settings
	input wire logic [7:0] nv_main_protect_i,
	input wire logic [7:0] nv_second_protect_i,
	input wire logic nv_secure_i,
	input wire logic [7:0] nv_mem_map_i,
	// configuration outputs
	output logic [7:0] drive_a_o,
	output logic [7:0] drive_b_o,
	output logic [7:0] drive_c_o,
	output logic [7:0] drive_d_o,
	output logic [7:0] output_macrocell_low_o,
	output logic [7:0] output_macrocell_high_o,
	output logic [7:0] power_ctrl_0_o,
	output logic [7:0] power_ctrl_2_o,
	output logic [7:0] power_ctrl_3_o,
	output logic [7:0] page_o,
	output logic [7:0] memory_space_map_o,
	output logic port_a_peripheral_io_enable_o
);

	// ----------------------------------------------------------------
	// synchronised status inputs
	// ----------------------------------------------------------------
	logic [7:0] incell_a, incell_b, incell_c;  // input macrocell state
	logic [7:0] oe_a, oe_b, oe_c, oe_d;        // driver enable state

	// one synchroniser for all seven status bytes keeps them coherent per edge
	rrbu_sync2 #(
		.WIDTH(56)
	) u_sync (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.async_i({input_macrocell_a_i, input_macrocell_b_i, input_macrocell_c_i,
			drv_en_a_i, drv_en_b_i, drv_en_c_i, drv_en_d_i}),
		.sync_o({incell_a, incell_b, incell_c, oe_a, oe_b, oe_c, oe_d})
	);

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	// host write hitting one offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs, input logic s);
		hit = s && (a == ofs);
	endfunction

	// ----------------------------------------------------------------
	// output macrocell banks
	// ----------------------------------------------------------------
	logic [7:0] cell_low, cell_high;  // cell flip-flop state
	logic [7:0] mask_low, mask_high;  // host masks

	// low bank
	rrbu_cell_bank u_low (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.logic_d_i(output_macrocell_low_d_i),
		.cell_we_i(hit(addr_i, rrbu_pkg::OFS_CELL_LOW, wr_i)),
		.mask_we_i(hit(addr_i, rrbu_pkg::OFS_MASK_LOW, wr_i)),
		.wdata_i(wdata_i),
		.cell_o(cell_low),
		.mask_o(mask_low)
	);

	// high bank
	rrbu_cell_bank u_high (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.logic_d_i(output_macrocell_high_d_i),
		.cell_we_i(hit(addr_i, rrbu_pkg::OFS_CELL_HIGH, wr_i)),
		.mask_we_i(hit(addr_i, rrbu_pkg::OFS_MASK_HIGH, wr_i)),
		.wdata_i(wdata_i),
		.cell_o(cell_high),
		.mask_o(mask_high)
	);

	// ----------------------------------------------------------------
	// writable registers
	// ----------------------------------------------------------------
	logic [7:0] drive_a_reg, drive_a_next;  // port drive selects
	logic [7:0] drive_b_reg, drive_b_next;
	logic [7:0] drive_c_reg, drive_c_next;
	logic [7:0] drive_d_reg, drive_d_next;
	logic [7:0] pwr0_reg, pwr0_next;        // power registers
	logic [7:0] pwr2_reg, pwr2_next;
	logic [7:0] pwr3_reg, pwr3_next;
	logic [7:0] page_reg, page_next;        // memory page
	logic [7:0] map_reg, map_next;          // memory-space map
	logic map_load_reg, map_load_next;      // first cycle after reset release
	logic [7:0] rdata_reg, rdata_next;      // read data holding flop
	logic [7:0] cell_low_reg, cell_high_reg;  // output copies of the cells
	logic pio_reg;                            // port A peripheral enable copy

	// next values; read-only offsets have no write term at all
	always_comb begin
		drive_a_next = drive_a_reg;
		drive_b_next = drive_b_reg;
		drive_c_next = drive_c_reg;
		drive_d_next = drive_d_reg;
		pwr0_next = pwr0_reg;
		pwr2_next = pwr2_reg;
		pwr3_next = pwr3_reg;
		page_next = page_reg;
		map_next = map_reg;
		map_load_next = 1'b0;
		if (hit(addr_i, rrbu_pkg::OFS_DRIVE_A, wr_i)) begin
			drive_a_next = wdata_i;
		end
		if (hit(addr_i, rrbu_pkg::OFS_DRIVE_B, wr_i)) begin
			drive_b_next = wdata_i;
		end
		if (hit(addr_i, rrbu_pkg::OFS_DRIVE_C, wr_i)) begin
			drive_c_next = wdata_i;
		end
		if (hit(addr_i, rrbu_pkg::OFS_DRIVE_D, wr_i)) begin
			drive_d_next = wdata_i;
		end
		if (hit(addr_i, rrbu_pkg::OFS_POWER_0, wr_i)) begin
			pwr0_next = wdata_i;
		end
		if (hit(addr_i, rrbu_pkg::OFS_POWER_2, wr_i)) begin
			pwr2_next = wdata_i;
		end
		if (hit(addr_i, rrbu_pkg::OFS_POWER_3, wr_i)) begin
			// sticky bit: software may set it, never clear it
			pwr3_next = wdata_i;
			pwr3_next[rrbu_pkg::POWER3_STICKY_BIT] = wdata_i[rrbu_pkg::POWER3_STICKY_BIT]
				| pwr3_reg[rrbu_pkg::POWER3_STICKY_BIT];
		end
		if (hit(addr_i, rrbu_pkg::OFS_PAGE, wr_i)) begin
			page_next = wdata_i;
		end
		if (map_load_reg) begin
			// nv bits loaded after reset; the strap is sampled by a clocked flop
			map_next = nv_mem_map_i & rrbu_pkg::MAP_NV_FIELDS;
		end
		if (hit(addr_i, rrbu_pkg::OFS_MEM_MAP, wr_i)) begin
			map_next = wdata_i;
		end
	end

	// read mux; unmapped and write-only-free offsets read as zero
	always_comb begin
		rdata_next = rdata_reg;
		if (rd_i) begin
			unique case (addr_i)
				rrbu_pkg::OFS_DRIVE_A: rdata_next = drive_a_reg;
				rrbu_pkg::OFS_DRIVE_B: rdata_next = drive_b_reg;
				rrbu_pkg::OFS_DRIVE_C: rdata_next = drive_c_reg;
				rrbu_pkg::OFS_DRIVE_D: rdata_next = drive_d_reg;
				rrbu_pkg::OFS_INCELL_A: rdata_next = incell_a;
				rrbu_pkg::OFS_INCELL_B: rdata_next = incell_b;
				rrbu_pkg::OFS_INCELL_C: rdata_next = incell_c;
				rrbu_pkg::OFS_OESTATE_A: rdata_next = oe_a;
				rrbu_pkg::OFS_OESTATE_B: rdata_next = oe_b;
				rrbu_pkg::OFS_OESTATE_C: rdata_next = oe_c;
				rrbu_pkg::OFS_OESTATE_D: rdata_next = oe_d;
				// masked cells read back as zero
				rrbu_pkg::OFS_CELL_LOW: rdata_next = cell_low & ~mask_low;
				rrbu_pkg::OFS_CELL_HIGH: rdata_next = cell_high & ~mask_high;
				rrbu_pkg::OFS_MASK_LOW: rdata_next = mask_low;
				rrbu_pkg::OFS_MASK_HIGH: rdata_next = mask_high;
				rrbu_pkg::OFS_POWER_0: rdata_next = pwr0_reg;
				rrbu_pkg::OFS_POWER_2: rdata_next = pwr2_reg;
				rrbu_pkg::OFS_POWER_3: rdata_next = pwr3_reg;
				rrbu_pkg::OFS_MAIN_PROT: rdata_next = nv_main_protect_i;
				rrbu_pkg::OFS_SEC_PROT: begin
					rdata_next = nv_second_protect_i;
					rdata_next[rrbu_pkg::SECURE_BIT] = nv_secure_i;
				end
				rrbu_pkg::OFS_PAGE: rdata_next = page_reg;
				rrbu_pkg::OFS_MEM_MAP: rdata_next = map_reg;
				default: rdata_next = rrbu_pkg::RST_ZERO;
			endcase
		end
	end

	// registers only; reset values push-pull drive and zero enable bit
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			drive_a_reg <= rrbu_pkg::RST_DRIVE;
			drive_b_reg <= rrbu_pkg::RST_DRIVE;
			drive_c_reg <= rrbu_pkg::RST_DRIVE;
			drive_d_reg <= rrbu_pkg::RST_DRIVE;
			pwr0_reg <= rrbu_pkg::RST_POWER;
			pwr2_reg <= rrbu_pkg::RST_POWER;
			pwr3_reg <= rrbu_pkg::RST_POWER;
			page_reg <= rrbu_pkg::RST_PAGE;
			map_reg <= rrbu_pkg::RST_ZERO;
			map_load_reg <= 1'b1;
			rdata_reg <= rrbu_pkg::RST_ZERO;
			cell_low_reg <= rrbu_pkg::RST_CELL;
			cell_high_reg <= rrbu_pkg::RST_CELL;
			pio_reg <= 1'b0;
		end else begin
			drive_a_reg <= drive_a_next;
			drive_b_reg <= drive_b_next;
			drive_c_reg <= drive_c_next;
			drive_d_reg <= drive_d_next;
			pwr0_reg <= pwr0_next;
			pwr2_reg <= pwr2_next;
			pwr3_reg <= pwr3_next;
			page_reg <= page_next;
			map_reg <= map_next;
			map_load_reg <= map_load_next;
			rdata_reg <= rdata_next;
			cell_low_reg <= cell_low;
			cell_high_reg <= cell_high;
			pio_reg <= map_next[rrbu_pkg::MAP_PORT_A_PERIPHERAL_IO_ENABLE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flops
	// ----------------------------------------------------------------
	assign rdata_o = rdata_reg;
	assign drive_a_o = drive_a_reg;
	assign drive_b_o = drive_b_reg;
	assign drive_c_o = drive_c_reg;
	assign drive_d_o = drive_d_reg;
	assign output_macrocell_low_o = cell_low_reg;  // one cycle behind the cell flops
	assign output_macrocell_high_o = cell_high_reg;
	assign power_ctrl_0_o = pwr0_reg;
	assign power_ctrl_2_o = pwr2_reg;
	assign power_ctrl_3_o = pwr3_reg;
	assign page_o = page_reg;
	assign memory_space_map_o = map_reg;
	assign port_a_peripheral_io_enable_o = pio_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	drive_write_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(wr_i && addr_i == rrbu_pkg::OFS_DRIVE_A) |=> (drive_a_o == $past(wdata_i)))
		else $error("drive select did not take write");

	drive_reset_pp_a: assert property (@(posedge clk_i)
		$rose(nrst_i) |->
		(drive_a_o == rrbu_pkg::RST_DRIVE && drive_d_o == rrbu_pkg::RST_DRIVE))
		else $error("drive select not push-pull after reset");

	incell_readback_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(rd_i && addr_i == rrbu_pkg::OFS_INCELL_A) |=> (rdata_o == $past(incell_a)))
		else $error("input macrocell read wrong");

	oe_readback_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(rd_i && addr_i == rrbu_pkg::OFS_OESTATE_D) |=> (rdata_o == $past(oe_d)))
		else $error("output enable state read wrong");

	cell_low_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(rd_i && addr_i == rrbu_pkg::OFS_CELL_LOW) |=>
		(rdata_o == ($past(cell_low) & ~$past(mask_low))))
		else $error("low cell bank read wrong");

	cell_high_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(wr_i && addr_i == rrbu_pkg::OFS_CELL_HIGH && mask_high == 8'h00) |=>
		(cell_high == $past(wdata_i)) ##1 (output_macrocell_high_o == $past(wdata_i, 2)))
		else $error("high cell bank not loaded");

	prot_readonly_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(rd_i && addr_i == rrbu_pkg::OFS_MAIN_PROT) |=> (rdata_o == $past(nv_main_protect_i)))
		else $error("main protection read wrong");

	power_rw_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(wr_i && addr_i == rrbu_pkg::OFS_POWER_2) |=> (power_ctrl_2_o == $past(wdata_i)))
		else $error("power register 2 not written");

	sticky_bit_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		power_ctrl_3_o[rrbu_pkg::POWER3_STICKY_BIT] |=>
		power_ctrl_3_o[rrbu_pkg::POWER3_STICKY_BIT])
		else $error("power 3 bit 1 cleared without reset");

	map_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(wr_i && addr_i == rrbu_pkg::OFS_MEM_MAP) |=> (memory_space_map_o == $past(wdata_i)))
		else $error("memory map write lost");

	pio_reset_zero_a: assert property (@(posedge clk_i)
		($rose(nrst_i) && !(wr_i && addr_i == rrbu_pkg::OFS_MEM_MAP)) |->
		!port_a_peripheral_io_enable_o ##1 !port_a_peripheral_io_enable_o)
		else $error("peripheral enable set after reset");

	readonly_ignored_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(wr_i && addr_i == rrbu_pkg::OFS_SEC_PROT && !map_load_reg) |=>
		($stable(drive_a_o) && $stable(map_reg)))
		else $error("read-only write changed state");

endmodule

// ===== tb/rrbu_host_model.sv
/*
 * host processor model: one-cycle write and read strobes on the register bus.
 * assumes the bank samples on the rising edge and answers a read one cycle later.
 */
module rrbu_host_model (
	// clock
	input wire logic clk_i,
	// register bus
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	input wire logic [7:0] rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;

	// bus idle at time zero
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// write: strobe spans one rising edge; released lines show inverted values
	// so a stale address or byte can never pass for a fresh one
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask

	// read: data is registered at the strobe's edge, taken one half cycle later
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		d = rdata_i;
		rd_o = 1'b0;
		addr_o = ~a;
	endtask
endmodule

// ===== tb/tb_top.sv
/*
 * self-checking bench for the upper run-time register bank.
 * assumes the host model drives the bus at falling edges; nv levels held static.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i, nrst_i, wr, rd, nv_secure, pio;
	logic [7:0] addr, wdata, rdata, in_a, in_b, in_c, en_a, en_b, en_c, en_d, d_lo, d_hi;
	logic [7:0] nv_main, nv_sec, nv_map, drv_a, cell_lo, cell_hi, pw3, map, v;
	logic [7:0] drv_b, drv_c, drv_d, pw0, pw2, pg;  // remaining register outputs
	int bad_count, checks;
	// read-write offsets and read-only offsets
	localparam logic [7:0] RW_OFS [7] = '{8'h08, 8'h09, 8'h16, 8'h17, 8'hB0, 8'hB4, 8'hE0};
	localparam logic [7:0] RO_OFS [9] = '{8'h0A, 8'h0B, 8'h18, 8'h0C, 8'h0D, 8'h1A, 8'h1B,
		8'hC0, 8'hC2};

	rrbu_host_model i_host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
		.rd_o(rd), .rdata_i(rdata));

	rrbu_bank i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .input_macrocell_a_i(in_a),
		.input_macrocell_b_i(in_b), .input_macrocell_c_i(in_c), .drv_en_a_i(en_a),
		.drv_en_b_i(en_b), .drv_en_c_i(en_c), .drv_en_d_i(en_d),
		.output_macrocell_low_d_i(d_lo), .output_macrocell_high_d_i(d_hi),
		.nv_main_protect_i(nv_main), .nv_second_protect_i(nv_sec), .nv_secure_i(nv_secure),
		.nv_mem_map_i(nv_map), .drive_a_o(drv_a), .drive_b_o(drv_b), .drive_c_o(drv_c),
		.drive_d_o(drv_d), .output_macrocell_low_o(cell_lo), .output_macrocell_high_o(cell_hi),
		.power_ctrl_0_o(pw0), .power_ctrl_2_o(pw2), .power_ctrl_3_o(pw3), .page_o(pg),
		.memory_space_map_o(map), .port_a_peripheral_io_enable_o(pio));

	// 40 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// reset pulse; three idle edges after release let synchronised inputs settle
	task automatic do_reset(input int n);
		@(negedge clk_i);
		nrst_i = 1'b0;
		repeat (n) @(negedge clk_i);
		nrst_i = 1'b1;
		repeat (3) @(negedge clk_i);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_vals();
		chk(drv_a, 8'h00);
		for (int i = 0; i < 4; i++) begin
			i_host.rd_reg(RW_OFS[i], v);
			chk(v, 8'h00);
		end
		chk(map, nv_map & 8'h1E);
		chk({7'h00, pio}, 8'h00);
	endtask

	// back-to-back distinct bytes, then read all: catches aliasing too
	task automatic t_rw();
		logic [7:0] o [7];
		for (int i = 0; i < 7; i++) i_host.wr_reg(RW_OFS[i], 8'h5A ^ 8'(i * 17));
		for (int i = 0; i < 7; i++) begin
			i_host.rd_reg(RW_OFS[i], v);
			chk(v, 8'h5A ^ 8'(i * 17));
		end
		chk(drv_a, 8'h5A);
		// output port of each register written above, in the same order as the offsets
		o = '{drv_a, drv_b, drv_c, drv_d, pw0, pw2, pg};
		for (int i = 0; i < 7; i++) chk(o[i], 8'h5A ^ 8'(i * 17));
	endtask

	// read-only places show live state and shrug off writes
	task automatic t_ro();
		logic [7:0] e [9];
		e = '{in_a, in_b, in_c, en_a, en_b, en_c, en_d, nv_main, {nv_sec[7:1], nv_secure}};
		for (int i = 0; i < 9; i++) begin
			i_host.wr_reg(RO_OFS[i], ~e[i]);
			i_host.rd_reg(RO_OFS[i], v);
			chk(v, e[i]);
		end
		i_host.rd_reg(8'h30, v);
		chk(v, 8'h00);
	endtask

	// one cell bank with its mask; masked bits keep logic value and read as zero
	task automatic t_cells(input bit hi);
		@(negedge clk_i);
		if (hi) d_hi = 8'hA5;
		else d_lo = 8'hA5;
		i_host.rd_reg(8'h20 + 8'(hi), v);
		chk(v, 8'hA5);
		i_host.wr_reg(8'h22 + 8'(hi), 8'hF0);
		i_host.rd_reg(8'h22 + 8'(hi), v);
		chk(v, 8'hF0);
		i_host.rd_reg(8'h20 + 8'(hi), v);
		chk(v, 8'h05);
		if (hi) d_hi = 8'h00;
		else d_lo = 8'h00;
		i_host.wr_reg(8'h20 + 8'(hi), 8'hFF);
		// output copy trails the cells by one edge; cells fall back to logic after that
		@(negedge clk_i);
		chk(hi ? cell_hi : cell_lo, 8'h0F);
		i_host.wr_reg(8'h22 + 8'(hi), 8'h00);
		// unmasked write lands whole
		i_host.wr_reg(8'h20 + 8'(hi), 8'h3C);
		@(negedge clk_i);
		chk(hi ? cell_hi : cell_lo, 8'h3C);
	endtask

	// sticky bit survives software clears, falls only at reset
	task automatic t_power3();
		i_host.wr_reg(8'hC7, 8'h02);
		i_host.wr_reg(8'hC7, 8'h00);
		i_host.rd_reg(8'hC7, v);
		chk(v, 8'h02);
		i_host.wr_reg(8'hC7, 8'hFD);
		i_host.rd_reg(8'hC7, v);
		chk(v, 8'hFF);
		chk(pw3, 8'hFF);
		do_reset(2);
		i_host.rd_reg(8'hC7, v);
		chk(v, 8'h00);
	endtask

	// software override of the map, then reset restores the nv fields
	task automatic t_map();
		i_host.wr_reg(8'hE2, 8'h8C);
		i_host.rd_reg(8'hE2, v);
		chk(v, 8'h8C);
		chk({7'h00, pio}, 8'h01);
		do_reset(2);
		i_host.rd_reg(8'hE2, v);
		chk(v, nv_map & 8'h1E);
	endtask

	// main sequence; all inputs valued at time zero
	initial begin
		{in_a, in_b, in_c, en_a, en_b, en_c, en_d} = 56'h11_2233_4455_6677;
		nv_main = 8'h99;
		nv_sec = 8'h3E;  // bit 0 differs from the secure flag to show the overlay
		nv_map = 8'hFF;  // bit 7 set so the forced-zero enable is visible
		nv_secure = 1'b1;
		d_lo = 8'h00;
		d_hi = 8'h00;
		nrst_i = 1'b0;
		bad_count = 0;
		checks = 0;
		// reset low from time zero for twelve clock periods
		do_reset(11);
		t_reset_vals();
		t_rw();
		t_ro();
		@(negedge clk_i);
		{in_a, in_b, in_c, en_a, en_b, en_c, en_d} = 56'hEE_DDCC_BBAA_9988;
		repeat (3) @(negedge clk_i);
		t_ro();
		t_cells(1'b0);
		t_cells(1'b1);
		t_power3();
		t_map();
		t_reset_vals();
		end_of_test();
	end

	// watchdog: run needs about 5 us, allow twenty times that
	initial begin
		#100000;
		bad_count++;
		end_of_test();
	end
endmodule
